// *** rpd_rmii_phy.sv ***
// rmii phy data path: strap and clock mode, reference clock, transmit intake, receive output
`timescale 1ns/1ps
`include "rpd_regs.svh"

// Functional notes
// - transmit and receive each move one two-bit dibit per reference clock
// - works at 10 and 100 Mbps, half or full duplex
// - straps 001 with clock-mode bit 0 give 25 MHz clock mode
// - straps 001 with clock-mode bit 1 give 50 MHz clock mode
// - one continuous 50 MHz reference clock times every data signal
// - 25 MHz mode: device makes the reference clock and drives it out
// - 50 MHz mode: reference taken at crystal input, clock output unused
// - while transmit enable is high, one dibit per clock is taken
// - carrier detection raises receive valid without waiting for alignment
// - loss of carrier drops receive valid
// - receive valid stays high first to last dibit, drops right after
// - receive data shows 00 after valid rises until decoding is ready
// - every clock with receive valid high after decoding is ready carries one recovered dibit
// - receive data idles at 00, or 01 for low-power idle
// - receive data changes only on the reference clock
// - receive error raised with valid high when a symbol error is seen once decoding is ready
module rpd_rmii_phy (
  input wire logic clk_in, // 100 MHz system clock
  input wire logic resetn_in, // async reset, active low
  input wire logic [`RPD_CFG_W-1:0] strap_cfg_in, // interface-select straps
  input wire logic clk_mode_50_in, // clock-mode select bit
  input wire logic eee_en_in, // energy-efficient operation in use
  input wire logic crystal_input_in, // 50 MHz reference in 50 MHz mode
  output logic ref_clk_out, // generated reference clock
  output logic rmii_sel_out, // straps chose rmii
  output logic mode_50_out, // 50 MHz clock mode active
  input wire logic txen_in, // mac transmit enable pin
  input wire logic [`RPD_DIBIT_W-1:0] txd_in, // mac transmit dibit pins
  output logic [`RPD_DIBIT_W-1:0] tx_dibit_out, // dibit toward the line coder
  output logic tx_valid_out, // tx_dibit_out holds a dibit
  input wire logic tx_ready_in, // line coder takes the dibit
  output logic tx_lpi_out, // mac signals low-power idle
  output logic tx_overflow_out, // a dibit was lost to a full buffer
  input wire logic line_carrier_in, // carrier detect from line side, async
  input wire logic rx_locked_in, // decoder delivers properly decoded dibits
  input wire logic [`RPD_DIBIT_W-1:0] rx_dibit_in, // recovered dibit
  input wire logic rx_sym_err_in, // symbol or coding error seen
  input wire logic rx_lpi_in, // receive side in low-power idle
  output logic crs_dv_out, // carrier sense and data valid to mac
  output logic [`RPD_DIBIT_W-1:0] rxd_out, // receive dibit to mac
  output logic rxer_out // receive error to mac
);
  localparam int HALF_CYC = `RPD_REF_HALF_CYC < 1 ? 1 : `RPD_REF_HALF_CYC;

  logic [2:0] xi_sync;
  logic txen_s1;
  logic txen_s2;
  logic txen_s3;
  logic [`RPD_DIBIT_W-1:0] txd_s1;
  logic [`RPD_DIBIT_W-1:0] txd_s2;
  logic [`RPD_DIBIT_W-1:0] txd_s3;
  logic car_s1;
  logic car_s2;
  logic straps_taken;
  logic rmii_sel;
  logic [7:0] div_cnt;
  logic gen_clk;
  logic [7:0] next_div_cnt;
  logic next_gen_clk;
  logic gen_rise;
  logic ref_edge;
  logic take_txen;
  logic [`RPD_DIBIT_W-1:0] take_txd;
  logic push;
  logic push_ready;
  logic next_overflow;
  logic next_lpi;
  rpd_pkg::rpd_rx_state_e rx_state;
  rpd_pkg::rpd_rx_state_e next_rx_state;
  logic next_crs;
  logic [`RPD_DIBIT_W-1:0] next_rxd;
  logic next_rxer;

  // straps are caught on the first edge after reset release, never by the reset itself
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      straps_taken <= 1'b0;
      rmii_sel <= 1'b0;
    end
    else if (!straps_taken)
    begin
      straps_taken <= 1'b1;
      rmii_sel <= (strap_cfg_in == `RPD_CFG_RMII);
    end
  end

  // crystal input, transmit pins and carrier each pass two flops before any logic reads them
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      xi_sync <= '0;
      txen_s1 <= 1'b0;
      txen_s2 <= 1'b0;
      txen_s3 <= 1'b0;
      txd_s1 <= `RPD_DIBIT_IDLE;
      txd_s2 <= `RPD_DIBIT_IDLE;
      txd_s3 <= `RPD_DIBIT_IDLE;
      car_s1 <= 1'b0;
      car_s2 <= 1'b0;
    end
    else
    begin
      xi_sync <= {xi_sync[1:0], crystal_input_in};
      txen_s1 <= txen_in;
      txen_s2 <= txen_s1;
      txen_s3 <= txen_s2;
      txd_s1 <= txd_in;
      txd_s2 <= txd_s1;
      txd_s3 <= txd_s2;
      car_s1 <= line_carrier_in;
      car_s2 <= car_s1;
    end
  end

  // reference divider; in 50 MHz mode it rests and the output stays low
  always_comb
  begin
    next_div_cnt = div_cnt;
    next_gen_clk = 1'b0;
    if (rmii_sel && !clk_mode_50_in)
    begin
      next_gen_clk = gen_clk;
      if (div_cnt == 8'(HALF_CYC - 1))
      begin
        next_div_cnt = '0;
        next_gen_clk = !gen_clk;
      end
      else
      begin
        next_div_cnt = div_cnt + 8'h01;
      end
    end
    else
    begin
      next_div_cnt = '0;
    end
    gen_rise = next_gen_clk && !gen_clk;
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      div_cnt <= '0;
      gen_clk <= 1'b0;
      ref_clk_out <= 1'b0;
      mode_50_out <= 1'b0;
      rmii_sel_out <= 1'b0;
    end
    else
    begin
      div_cnt <= next_div_cnt;
      gen_clk <= next_gen_clk;
      ref_clk_out <= next_gen_clk;
      mode_50_out <= rmii_sel && clk_mode_50_in;
      rmii_sel_out <= rmii_sel;
    end
  end

  // a single edge strobe times both directions; the mac's own edge is seen late
  // by the synchroniser, so in 50 MHz mode the data one stage older is the stable one
  always_comb
  begin
    ref_edge = 1'b0;
    take_txen = txen_s2;
    take_txd = txd_s2;
    if (rmii_sel && clk_mode_50_in)
    begin
      ref_edge = xi_sync[1] && !xi_sync[2];
      take_txen = txen_s3;
      take_txd = txd_s3;
    end
    else if (rmii_sel)
    begin
      ref_edge = gen_rise;
    end
  end

  // transmit intake: one dibit per reference edge while enable is high
  always_comb
  begin
    push = ref_edge && take_txen;
    next_overflow = push && !push_ready;
    next_lpi = tx_lpi_out;
    if (ref_edge)
    begin
      next_lpi = eee_en_in && !take_txen && (take_txd == `RPD_DIBIT_LPI);
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      tx_overflow_out <= 1'b0;
      tx_lpi_out <= 1'b0;
    end
    else
    begin
      tx_overflow_out <= next_overflow;
      tx_lpi_out <= next_lpi;
    end
  end

  // buffer lets the line coder stall; overflow is only reported, the mac cannot wait
  rpd_fifo #(
    .WIDTH(`RPD_DIBIT_W),
    .DEPTH(`RPD_FIFO_DEPTH),
    .AW(`RPD_FIFO_AW)
  ) u_tx_fifo (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .in_valid_in(push),
    .in_ready_out(push_ready),
    .in_data_in(take_txd),
    .out_valid_out(tx_valid_out),
    .out_ready_in(tx_ready_in),
    .out_data_out(tx_dibit_out)
  );

  // receive side; carrier is taken at the next edge, which is as early as a flop can be
  always_comb
  begin
    next_rx_state = rx_state;
    case (rx_state)
      rpd_pkg::RPD_RX_IDLE:
      begin
        if (car_s2)
        begin
          next_rx_state = rpd_pkg::RPD_RX_WAIT;
        end
      end
      rpd_pkg::RPD_RX_WAIT:
      begin
        if (!car_s2)
        begin
          next_rx_state = rpd_pkg::RPD_RX_IDLE;
        end
        else if (rx_locked_in)
        begin
          next_rx_state = rpd_pkg::RPD_RX_DATA;
        end
      end
      default:
      begin
        if (!car_s2)
        begin
          next_rx_state = rpd_pkg::RPD_RX_IDLE;
        end
      end
    endcase
    if (!ref_edge)
    begin
      next_rx_state = rx_state;
    end
    next_crs = crs_dv_out;
    next_rxd = rxd_out;
    next_rxer = rxer_out;
    if (ref_edge)
    begin
      next_crs = (next_rx_state != rpd_pkg::RPD_RX_IDLE);
      next_rxer = 1'b0;
      if (next_rx_state == rpd_pkg::RPD_RX_DATA)
      begin
        next_rxd = rx_dibit_in;
        next_rxer = rx_sym_err_in;
      end
      else if (next_rx_state == rpd_pkg::RPD_RX_WAIT)
      begin
        next_rxd = `RPD_DIBIT_IDLE;
      end
      else
      begin
        next_rxd = (eee_en_in && rx_lpi_in) ? `RPD_DIBIT_LPI : `RPD_DIBIT_IDLE;
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rx_state <= rpd_pkg::RPD_RX_IDLE;
      crs_dv_out <= 1'b0;
      rxd_out <= `RPD_DIBIT_IDLE;
      rxer_out <= 1'b0;
    end
    else
    begin
      rx_state <= next_rx_state;
      crs_dv_out <= next_crs;
      rxd_out <= next_rxd;
      rxer_out <= next_rxer;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  sequence carrier_seen_s;
    ref_edge && rx_state == rpd_pkg::RPD_RX_IDLE && car_s2;
  endsequence
  sequence wait_entered_s;
    crs_dv_out && rxd_out == `RPD_DIBIT_IDLE && !rxer_out;
  endsequence

  crs_rises_carrier_a: assert property (carrier_seen_s |=> wait_entered_s)
    else $error("receive valid did not rise on carrier with idle data");
  crs_drops_loss_a: assert property (ref_edge && !car_s2 |=> !crs_dv_out && !rxer_out)
    else $error("receive valid stayed high after carrier loss");
  rx_dibit_passed_a: assert property (ref_edge && car_s2
    && rx_state == rpd_pkg::RPD_RX_DATA |=> crs_dv_out && rxd_out == $past(rx_dibit_in))
    else $error("recovered dibit not delivered");
  // the idle code holds between reference edges even if the enable drops meanwhile
  rx_idle_code_a: assert property (!crs_dv_out |-> rxd_out == `RPD_DIBIT_IDLE
    || (rxd_out == `RPD_DIBIT_LPI && $past(!crs_dv_out && rxd_out == `RPD_DIBIT_LPI
    || eee_en_in && rx_lpi_in)))
    else $error("receive idle code wrong");
  rx_sync_change_a: assert property (!$stable(rxd_out) || !$stable(crs_dv_out)
    |-> $past(ref_edge))
    else $error("receive outputs changed off the reference edge");
  rxer_in_frame_a: assert property (rxer_out |-> crs_dv_out
    && $past(rx_sym_err_in && ref_edge || rxer_out && !ref_edge))
    else $error("receive error outside a frame or without cause");
  tx_take_dibit_a: assert property (ref_edge && take_txen && push_ready
    |=> u_tx_fifo.count == $past(u_tx_fifo.count) + 5'h01
    - 5'($past(tx_ready_in && tx_valid_out)))
    else $error("transmit dibit not taken");
  ref_out_idle_a: assert property (mode_50_out |=> !ref_clk_out)
    else $error("reference output active in 50 MHz mode");
  ref_out_toggle_a: assert property (rmii_sel && !clk_mode_50_in && straps_taken
    ##0 $past(rmii_sel && !clk_mode_50_in) [*2]
    |-> ##[0:2] ref_clk_out ##[1:2] !ref_clk_out)
    else $error("reference output not running in 25 MHz mode");
  mode_select_a: assert property (straps_taken
    |=> mode_50_out == $past(rmii_sel && clk_mode_50_in))
    else $error("clock mode does not follow straps and select bit");
endmodule

// *** rpd_regs.svh ***
// constants for the rmii phy data interface block
`ifndef RPD_REGS_SVH
`define RPD_REGS_SVH

`define RPD_CLK_MHZ 100
`define RPD_REF_PERIOD_NS 20
`define RPD_REF_HALF_CYC ((`RPD_REF_PERIOD_NS * `RPD_CLK_MHZ) / 2000)
`define RPD_CFG_W 3
`define RPD_CFG_RMII 3'h1
`define RPD_CFG_RESET 3'h0
`define RPD_DIBIT_W 2
`define RPD_DIBIT_IDLE 2'h0
`define RPD_DIBIT_LPI 2'h1
`define RPD_FIFO_DEPTH 16
`define RPD_FIFO_AW 4

`endif

// *** rpd_pkg.sv ***
// types shared by the rmii phy data interface
package rpd_pkg;
  typedef enum logic [1:0] {RPD_RX_IDLE, RPD_RX_WAIT, RPD_RX_DATA} rpd_rx_state_e;
endpackage

// *** rpd_fifo.sv ***
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module rpd_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clk_in, // system clock
  input wire logic resetn_in, // async reset, active low
  input wire logic in_valid_in, // write request
  output logic in_ready_out, // not full
  input wire logic [WIDTH-1:0] in_data_in, // write data
  output logic out_valid_out, // not empty
  input wire logic out_ready_in, // reader takes the word
  output logic [WIDTH-1:0] out_data_out // head word, registered
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  always_comb
  begin
    push = in_valid_in && in_ready_out;
    pop = out_valid_out && out_ready_in;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count = count;
    if (push && !pop)
    begin
      next_count = count + 1'b1;
    end
    else if (pop && !push)
    begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready_out <= 1'b1;
      out_valid_out <= 1'b0;
      out_data_out <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      in_ready_out <= (next_count != (AW+1)'(DEPTH));
      out_valid_out <= (next_count != '0);
      // head word taken from memory, or straight from the write when it lands in empty
      if (next_count != '0)
      begin
        out_data_out <= (count == '0 || (count == (AW+1)'(1) && pop)) && push ?
                        in_data_in : mem[next_rd_ptr];
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data_in;
    end
  end
endmodule

// *** rpd_mac_model.sv ***
// behavioural mac with an rmii port, the far side of the phy data path
`timescale 1ns/1ps
module rpd_mac_model (
  input wire logic ref_clk_in, // rmii reference clock
  input wire logic half_dup_in, // half-duplex operation
  input wire logic lpi_in, // ask for low-power idle
  output logic txen_out, // transmit enable
  output logic [1:0] txd_out, // transmit dibit
  input wire logic crs_dv_in, // carrier sense and data valid
  input wire logic [1:0] rxd_in, // receive dibit
  input wire logic rxer_in, // receive error
  output logic col_out // regenerated collision
);
  logic [1:0] rx_q[$];
  int rxer_cnt = 0;
  logic busy = 1'b0;
  initial
  begin
    txen_out = 1'b0;
    txd_out = 2'h0;
  end
  // no collision pin on the link, so it is rebuilt here
  assign col_out = half_dup_in & txen_out & crs_dv_in;
  // receive lines are read mid-period: in 25 MHz mode they change in the very
  // time step of the rising reference edge, so a rising-edge read would race
  always @(negedge ref_clk_in)
  begin
    if (crs_dv_in)
      rx_q.push_back(rxd_in);
    if (crs_dv_in && rxer_in)
      rxer_cnt++;
  end
  always @(posedge ref_clk_in)
  begin
    if (!busy)
      txd_out <= #1 (lpi_in ? 2'h1 : 2'h0);
  end
  task automatic send(input logic [1:0] d[32], input int n);
    busy = 1'b1;
    for (int k = 0; k < n; k++)
    begin
      @(posedge ref_clk_in);
      txen_out <= #1 1'b1;
      txd_out <= #1 d[k];
    end
    @(posedge ref_clk_in);
    txen_out <= #1 1'b0;
    txd_out <= #1 (lpi_in ? 2'h1 : 2'h0);
    #2 busy = 1'b0;
  endtask
endmodule

// *** test_rmii_phy_data_interface.sv ***
// self-checking bench for the rmii phy data path
`timescale 1ns/1ps
`include "rpd_regs.svh"
module test_rmii_phy_data_interface;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [2:0] strap = 3'h1;
  logic m50 = 1'b0;
  logic eee = 1'b0;
  logic xtal = 1'b0;
  logic rdy = 1'b1;
  logic car = 1'b0;
  logic lock = 1'b0;
  logic [1:0] rdib = 2'h0;
  logic serr = 1'b0;
  logic rlpi = 1'b0;
  logic half = 1'b0;
  logic mlpi = 1'b0;
  logic txen, ref_clk_out, rmii_sel_out, mode_50_out, tx_valid_out;
  logic tx_lpi_out, tx_overflow_out, crs_dv_out, rxer_out, col;
  logic [1:0] txd, tx_dibit_out, rxd_out;
  logic [1:0] txq[$];
  int ovf = 0;
  int col_cnt = 0;
  int cyc = 0;
  int num_errors = 0;
  int n_tests = 0;
  wire logic ref_clk = m50 ? xtal : ref_clk_out;

  initial
  begin
    forever #5 clk_in = ~clk_in;
  end
  // link reference, phase unrelated to the system clock
  initial
  begin
    #3;
    forever #80 xtal = ~xtal;
  end

  rpd_rmii_phy i_rpd_rmii_phy (.clk_in(clk_in), .resetn_in(resetn_in),
    .strap_cfg_in(strap), .clk_mode_50_in(m50), .eee_en_in(eee),
    .crystal_input_in(xtal), .ref_clk_out(ref_clk_out),
    .rmii_sel_out(rmii_sel_out), .mode_50_out(mode_50_out), .txen_in(txen),
    .txd_in(txd), .tx_dibit_out(tx_dibit_out), .tx_valid_out(tx_valid_out),
    .tx_ready_in(rdy), .tx_lpi_out(tx_lpi_out), .tx_overflow_out(tx_overflow_out),
    .line_carrier_in(car), .rx_locked_in(lock), .rx_dibit_in(rdib),
    .rx_sym_err_in(serr), .rx_lpi_in(rlpi), .crs_dv_out(crs_dv_out),
    .rxd_out(rxd_out), .rxer_out(rxer_out));

  rpd_mac_model i_rpd_mac_model (.ref_clk_in(ref_clk), .half_dup_in(half),
    .lpi_in(mlpi), .txen_out(txen), .txd_out(txd), .crs_dv_in(crs_dv_out),
    .rxd_in(rxd_out), .rxer_in(rxer_out), .col_out(col));

  task automatic summarize;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // line coder side: pops the head word whenever ready
  always @(posedge clk_in)
  begin
    cyc++;
    if (tx_valid_out === 1'b1 && rdy === 1'b1)
      txq.push_back(tx_dibit_out);
    if (tx_overflow_out === 1'b1)
      ovf++;
    if (col === 1'b1)
      col_cnt++;
    if (cyc == 6000)
    begin
      $display("[ERR] cycle limit expected 0 seen 1");
      num_errors++;
      summarize;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
      num_errors++;
    end
  endtask

  function automatic logic [1:0] pat(input int k, input int s);
    return 2'((k * s + 1) % 4);
  endfunction

  task automatic do_reset(input logic [2:0] s, input logic m);
    @(posedge clk_in);
    #1 resetn_in = 1'b0;
    strap = s;
    m50 = m;
    repeat (10) @(posedge clk_in);
    #1 resetn_in = 1'b1;
    repeat (4) @(posedge clk_in);
  endtask

  task automatic t_mode(input logic s, input logic m, input int t);
    int tg;
    logic p;
    tg = 0;
    #1 p = ref_clk_out;
    repeat (40)
    begin
      @(posedge clk_in);
      #1;
      if (ref_clk_out !== p)
        tg++;
      p = ref_clk_out;
    end
    chk("rmii select", 32'(s), 32'(rmii_sel_out));
    chk("clock mode 50", 32'(m), 32'(mode_50_out));
    chk("ref clock toggles", t, tg);
  endtask

  task automatic wait_q(input int n);
    for (int i = 0; i < 400 && txq.size() < n; i++)
      @(posedge clk_in);
    repeat (20) @(posedge clk_in);
  endtask

  task automatic t_tx(input int n);
    logic [1:0] d[32];
    for (int k = 0; k < 32; k++)
      d[k] = pat(k, 3);
    txq.delete();
    i_rpd_mac_model.send(d, n);
    wait_q(n);
    chk("tx count", n, txq.size());
    for (int k = 0; k < n && k < txq.size(); k++)
      chk("tx dibit", 32'(d[k]), 32'(txq[k]));
  endtask

  task automatic t_rx(input int n, input int e);
    int z;
    int r;
    i_rpd_mac_model.rx_q.delete();
    i_rpd_mac_model.rxer_cnt = 0;
    @(posedge ref_clk);
    #1 car = 1'b1;
    rdib = 2'h3;
    repeat (3) @(posedge ref_clk);
    for (int k = 0; k < n; k++)
    begin
      @(posedge ref_clk);
      #1 lock = 1'b1;
      rdib = pat(k, 5);
      serr = (k == e);
    end
    @(posedge ref_clk);
    #1 car = 1'b0;
    lock = 1'b0;
    rdib = 2'h0;
    serr = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 z = 0;
    while (z < i_rpd_mac_model.rx_q.size() && i_rpd_mac_model.rx_q[z] === 2'h0)
      z++;
    r = i_rpd_mac_model.rx_q.size() - z;
    chk("rx held zeros", 1, 32'(z >= 2));
    chk("rx length", 1, 32'(r == n || r == n + 1));
    for (int k = 0; k < n && k < r; k++)
      chk("rx dibit", 32'(pat(k, 5)), 32'(i_rpd_mac_model.rx_q[z + k]));
    chk("rx error cycles", 32'(e >= 0), i_rpd_mac_model.rxer_cnt);
    chk("valid after loss", 0, 32'(crs_dv_out));
    chk("rx idle code", 0, 32'(rxd_out));
  endtask

  task automatic t_fill;
    logic [1:0] d[32];
    for (int k = 0; k < 32; k++)
      d[k] = pat(k, 3);
    @(posedge clk_in);
    #1 rdy = 1'b0;
    txq.delete();
    ovf = 0;
    i_rpd_mac_model.send(d, 20);
    repeat (10) @(posedge clk_in);
    #1 chk("overflow pulses", 4, ovf);
    chk("head stands", 1, 32'(tx_valid_out));
    rdy = 1'b1;
    wait_q(16);
    chk("drain count", 16, txq.size());
    for (int k = 0; k < 16 && k < txq.size(); k++)
      chk("drain dibit", 32'(d[k]), 32'(txq[k]));
    chk("drained empty", 0, 32'(tx_valid_out));
  endtask

  task automatic t_lpi;
    @(posedge clk_in);
    #1 eee = 1'b1;
    mlpi = 1'b1;
    rlpi = 1'b1;
    repeat (10) @(posedge ref_clk);
    #1 chk("tx lpi", 1, 32'(tx_lpi_out));
    chk("rx lpi code", 1, 32'(rxd_out));
    eee = 1'b0;
    repeat (10) @(posedge ref_clk);
    #1 chk("tx lpi off", 0, 32'(tx_lpi_out));
    chk("rx normal idle", 0, 32'(rxd_out));
    mlpi = 1'b0;
    rlpi = 1'b0;
  endtask

  task automatic t_col(input logic h);
    half = h;
    col_cnt = 0;
    fork
      t_tx(12);
      t_rx(10, -1);
    join
    chk("collision seen", 32'(h), 32'(col_cnt > 0));
  endtask

  initial
  begin
    do_reset(3'h1, 1'b0);
    t_mode(1'b1, 1'b0, 40);
    t_tx(12);
    t_rx(10, 4);
    t_fill;
    t_lpi;
    t_col(1'b1);
    t_col(1'b0);
    do_reset(3'h1, 1'b1);
    t_mode(1'b1, 1'b1, 0);
    t_tx(12);
    t_rx(10, 7);
    do_reset(3'h0, 1'b0);
    t_mode(1'b0, 1'b0, 0);
    summarize;
  end
endmodule
